// [shared/sju_pkg.sv]
package sju_pkg;

  // register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFS_INSTR    = 8'h00;
  localparam logic [7:0] OFS_PSW      = 8'h04;
  localparam logic [7:0] OFS_INDEX    = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0C;
  localparam logic [7:0] OFS_MEM_ADDR = 8'h10;
  localparam logic [7:0] OFS_MEM_DATA = 8'h14;

  // data memory shape
  localparam int unsigned NIBBLE_W   = 4;
  localparam int unsigned DMEM_AW    = 4;
  localparam int unsigned DMEM_DEPTH = 16;

  // instruction word fields
  localparam int unsigned INSTR_ADDR_LSB = 0;
  localparam int unsigned INSTR_OPND_LSB = 4;
  localparam int unsigned INSTR_OP_LSB   = 8;
  localparam int unsigned OP_W           = 3;

  // program status word bit positions
  localparam int unsigned PSW_CARRY = 0;
  localparam int unsigned PSW_ZERO  = 1;
  localparam int unsigned PSW_CMP   = 2;
  localparam int unsigned PSW_IXE   = 3;

  // status register bit positions
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_SKIP = 1;
  localparam int unsigned ST_SUPP = 2;

  // byte enables needed by the instruction register and the rest
  localparam logic [3:0] STRB_INSTR = 4'h3;
  localparam logic [3:0] STRB_LOW   = 4'h1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [3:0] NIBBLE_ZERO = 4'h0;

  typedef enum logic [OP_W-1:0] {
    skip_if_bits_set,
    skip_if_bits_clear,
    skip_if_equal,
    skip_if_not_equal,
    skip_if_greater_or_equal,
    skip_if_less_than,
    add_immediate,
    no_operation
  } judge_op_t;

  typedef enum logic [1:0] {
    st_idle,
    st_fetch,
    st_eval
  } state_t;

endpackage

// [shared/dmem_if.sv]
`timescale 1ns/1ps
interface dmem_if;
  import sju_pkg::*;
  logic                we;
  logic [DMEM_AW-1:0]  waddr;
  logic [NIBBLE_W-1:0] wdata;
  logic [DMEM_AW-1:0]  raddr;
  logic [NIBBLE_W-1:0] rdata;
  modport core (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// [rtl/nibble_memory.sv]
`timescale 1ns/1ps
module nibble_memory
  import sju_pkg::*;
(
  input wire logic aclk,
  dmem_if.mem      port
);

  logic [NIBBLE_W-1:0] cells [DMEM_DEPTH];

  // one write port, registered read port; read shows old data on collision
  always_ff @(posedge aclk) begin
    if (port.we) begin
      cells[port.waddr] <= port.wdata;
    end
    port.rdata <= cells[port.raddr];
  end

endmodule

// [rtl/skip_judgement_unit.sv]
`timescale 1ns/1ps
// Behaviour
// RL1 - skip when all masked bits are one
// RL2 - skip when all masked bits are zero
// RL3 - bit tests read data memory only
// RL4 - bit tests keep carry and zero
// RL5 - bit tests clear the compare-only flag
// RL6 - index enable adds index to address
// RL7 - compares use memory nibble and immediate
// RL8 - equal compare skips on equality
// RL9 - not-equal compare skips on difference
// RL10 - greater-or-equal compare skips when memory bigger or equal
// RL11 - less-than compare skips when memory smaller
// RL12 - compares keep carry, zero, compare-only
// RL13 - compare-only arithmetic updates flags, no write
// RL14 - magnitudes are unsigned zero to fifteen
// RL15 - skip suppresses exactly one following instruction
module skip_judgement_unit
  import sju_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             skip_request
);

  dmem_if dm ();

  nibble_memory mem_i (
    .aclk (aclk),
    .port (dm)
  );

  state_t              state;
  judge_op_t           op;
  logic [NIBBLE_W-1:0] opnd;
  logic [DMEM_AW-1:0]  addr;
  logic [DMEM_AW-1:0]  index;
  logic [DMEM_AW-1:0]  mem_addr;
  logic [DMEM_AW-1:0]  exec_addr;
  logic                carry_flag;
  logic                zero_flag;
  logic                compare_only_flag;
  logic                index_enable_flag;
  logic                last_suppressed;
  logic                rd_wait;
  logic [7:0]          rd_addr;
  logic                wr_go;
  logic                rd_go;
  logic                wr_fire;
  logic                issue;
  logic                evaluating;
  logic                is_bit_op;
  logic                is_cmp_op;
  logic                judge;
  logic [NIBBLE_W-1:0] nib;
  logic [NIBBLE_W:0]   sum;
  logic                sum_zero;
  logic [31:0]         rd_word;
  logic                rd_hit;

  // write path waits for both channels; reads and writes never overlap
  assign wr_go   = awvalid && wvalid && !awready && !bvalid && state == st_idle
                   && !arready && !rd_wait && !rvalid;
  assign rd_go   = arvalid && !arready && !rd_wait && !rvalid && state == st_idle
                   && !wr_go && !awready && !bvalid;
  assign wr_fire = awready && awvalid && wready && wvalid;
  assign issue   = wr_fire && awaddr == OFS_INSTR && wstrb[1:0] == STRB_INSTR[1:0];

  // operand address, with optional index modification
  always_comb begin
    exec_addr = addr;
    if (index_enable_flag) begin
      exec_addr = DMEM_AW'(addr + index); // RL6
    end
  end

  // tested operand always comes from data memory, never a register
  assign nib        = dm.rdata; // RL3 RL7
  assign evaluating = state == st_eval;
  assign is_bit_op  = op == skip_if_bits_set || op == skip_if_bits_clear;
  assign is_cmp_op  = op == skip_if_equal || op == skip_if_not_equal
                      || op == skip_if_greater_or_equal || op == skip_if_less_than;
  assign sum        = {1'b0, nib} + {1'b0, opnd};
  assign sum_zero   = sum[NIBBLE_W-1:0] == NIBBLE_ZERO;

  // judgement; logic vectors compare unsigned, so 0..15 throughout
  always_comb begin
    judge = 1'b0;
    case (op)
      skip_if_bits_set:         judge = (nib & opnd) == opnd; // RL1
      skip_if_bits_clear:       judge = (nib & opnd) == NIBBLE_ZERO; // RL2
      skip_if_equal:            judge = nib == opnd; // RL8
      skip_if_not_equal:        judge = nib != opnd; // RL9
      skip_if_greater_or_equal: judge = nib >= opnd; // RL10 RL14
      skip_if_less_than:        judge = nib < opnd; // RL11 RL14
      default:                  judge = 1'b0;
    endcase
  end

  // memory ports: bus access while idle, execution otherwise
  always_comb begin
    dm.raddr = (state == st_idle) ? mem_addr : exec_addr;
    dm.we    = 1'b0;
    dm.waddr = mem_addr;
    dm.wdata = wdata[NIBBLE_W-1:0];
    if (evaluating && op == add_immediate) begin
      dm.we    = !compare_only_flag; // RL13
      dm.waddr = exec_addr;
      dm.wdata = sum[NIBBLE_W-1:0];
    end else if (wr_fire && awaddr == OFS_MEM_DATA && wstrb[0]) begin
      dm.we = 1'b1;
    end
  end

  // sequencer: issue, fetch operand, evaluate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= st_idle;
      op    <= no_operation;
      opnd  <= NIBBLE_ZERO;
      addr  <= NIBBLE_ZERO;
    end else begin
      case (state)
        st_idle: begin
          if (issue && !skip_request) begin
            op    <= judge_op_t'(wdata[INSTR_OP_LSB +: OP_W]);
            opnd  <= wdata[INSTR_OPND_LSB +: NIBBLE_W];
            addr  <= wdata[INSTR_ADDR_LSB +: DMEM_AW];
            state <= st_fetch;
          end
        end
        st_fetch: state <= st_eval;
        st_eval:  state <= st_idle;
        default:  state <= st_idle;
      endcase
    end
  end

  // skip request; the instruction issued while it stands does nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      skip_request    <= 1'b0;
      last_suppressed <= 1'b0;
    end else if (issue && skip_request) begin
      skip_request    <= 1'b0; // RL15
      last_suppressed <= 1'b1;
    end else if (issue) begin
      last_suppressed <= 1'b0;
    end else if (evaluating && (is_bit_op || is_cmp_op)) begin
      skip_request <= judge;
    end
  end

  // program status word; bus writes cannot meet an evaluation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carry_flag        <= 1'b0;
      zero_flag         <= 1'b0;
      compare_only_flag <= 1'b0;
      index_enable_flag <= 1'b0;
    end else if (wr_fire && awaddr == OFS_PSW && wstrb[0]) begin
      carry_flag        <= wdata[PSW_CARRY];
      zero_flag         <= wdata[PSW_ZERO];
      compare_only_flag <= wdata[PSW_CMP];
      index_enable_flag <= wdata[PSW_IXE];
    end else if (evaluating && is_bit_op) begin
      compare_only_flag <= 1'b0; // RL4 RL5
    end else if (evaluating && op == add_immediate) begin
      carry_flag <= sum[NIBBLE_W]; // RL13
      // compare-only chains keep zero across zero results
      if (compare_only_flag) begin
        zero_flag <= sum_zero && zero_flag;
      end else begin
        zero_flag <= sum_zero;
      end
    end
  end

  // plain software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      index    <= NIBBLE_ZERO;
      mem_addr <= NIBBLE_ZERO;
    end else if (wr_fire && wstrb[0]) begin
      if (awaddr == OFS_INDEX) begin
        index <= wdata[DMEM_AW-1:0];
      end else if (awaddr == OFS_MEM_ADDR) begin
        mem_addr <= wdata[DMEM_AW-1:0];
      end
    end
  end

  // write channel handshake and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      awready <= wr_go;
      wready  <= wr_go;
      if (wr_fire) begin
        bvalid <= 1'b1;
        if (awaddr == OFS_INSTR || awaddr == OFS_PSW || awaddr == OFS_INDEX
            || awaddr == OFS_MEM_ADDR || awaddr == OFS_MEM_DATA) begin
          bresp <= RESP_OKAY;
        end else begin
          bresp <= RESP_SLVERR; // status is read only, rest unmapped
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read data mux; memory read data is one cycle behind its address
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (rd_addr == OFS_INSTR) begin
      rd_word[INSTR_OP_LSB +: OP_W]       = op;
      rd_word[INSTR_OPND_LSB +: NIBBLE_W] = opnd;
      rd_word[INSTR_ADDR_LSB +: DMEM_AW]  = addr;
    end else if (rd_addr == OFS_PSW) begin
      rd_word[PSW_CARRY] = carry_flag;
      rd_word[PSW_ZERO]  = zero_flag;
      rd_word[PSW_CMP]   = compare_only_flag;
      rd_word[PSW_IXE]   = index_enable_flag;
    end else if (rd_addr == OFS_INDEX) begin
      rd_word[DMEM_AW-1:0] = index;
    end else if (rd_addr == OFS_STATUS) begin
      rd_word[ST_BUSY] = state != st_idle;
      rd_word[ST_SKIP] = skip_request;
      rd_word[ST_SUPP] = last_suppressed;
    end else if (rd_addr == OFS_MEM_ADDR) begin
      rd_word[DMEM_AW-1:0] = mem_addr;
    end else if (rd_addr == OFS_MEM_DATA) begin
      rd_word[NIBBLE_W-1:0] = dm.rdata;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // read channel: address taken, one wait cycle, then data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rd_wait <= 1'b0;
      rd_addr <= 8'h00;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= rd_go;
      if (arready && arvalid) begin
        rd_addr <= araddr;
        rd_wait <= 1'b1;
      end else if (rd_wait) begin
        rd_wait <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_word;
        rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // helper copy of the nibble that was judged, one cycle late for the checks
  logic [NIBBLE_W-1:0] nib_q;
  always_ff @(posedge aclk) begin
    nib_q <= nib;
  end

  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_eval_bit;
    evaluating && is_bit_op;
  endsequence

  sequence s_eval_cmp;
    evaluating && is_cmp_op;
  endsequence

  sequence s_issue_run;
    issue && !skip_request && state == st_idle ##1 state == st_fetch;
  endsequence

  AST_BITS_SET: assert property ( // RL1
    evaluating && op == skip_if_bits_set |=> skip_request == ((nib_q & opnd) == opnd))
    else $error("set-bit test skip wrong");

  AST_BITS_CLEAR: assert property ( // RL2
    evaluating && op == skip_if_bits_clear |=> skip_request == ((nib_q & opnd) == NIBBLE_ZERO))
    else $error("clear-bit test skip wrong");

  AST_FROM_MEMORY: assert property ( // RL3
    s_issue_run |-> dm.raddr == exec_addr ##1 evaluating && nib == dm.rdata)
    else $error("tested operand not from data memory");

  AST_BIT_FLAGS: assert property ( // RL4
    s_eval_bit |=> $stable(carry_flag) && $stable(zero_flag))
    else $error("bit test changed carry or zero");

  AST_BIT_CMP_CLEAR: assert property ( // RL5
    s_eval_bit |=> !compare_only_flag)
    else $error("bit test left compare-only set");

  AST_INDEX_ADDR: assert property ( // RL6
    state == st_fetch |-> dm.raddr == (index_enable_flag ? DMEM_AW'(addr + index) : addr))
    else $error("operand address not index modified");

  AST_EQUAL: assert property ( // RL8
    evaluating && op == skip_if_equal |=> skip_request == (nib_q == opnd))
    else $error("equal compare skip wrong");

  AST_NOT_EQUAL: assert property ( // RL9
    evaluating && op == skip_if_not_equal |=> skip_request == (nib_q != opnd))
    else $error("not-equal compare skip wrong");

  AST_GREATER_EQ: assert property ( // RL10 RL14
    evaluating && op == skip_if_greater_or_equal
    |=> skip_request == ({1'b0, nib_q} >= {1'b0, opnd}))
    else $error("greater-or-equal compare skip wrong");

  AST_LESS: assert property ( // RL11 RL14
    evaluating && op == skip_if_less_than |=> skip_request == ({1'b0, nib_q} < {1'b0, opnd}))
    else $error("less-than compare skip wrong");

  AST_CMP_FLAGS: assert property ( // RL12
    s_eval_cmp |=> $stable(carry_flag) && $stable(zero_flag) && $stable(compare_only_flag))
    else $error("compare changed a flag");

  AST_NO_WRITEBACK: assert property ( // RL13
    evaluating && op == add_immediate && compare_only_flag |-> !dm.we)
    else $error("compare-only arithmetic wrote memory");

  AST_SUPPRESS_ONE: assert property ( // RL15
    issue && skip_request |=> (state == st_idle && !skip_request && last_suppressed
    && $stable(carry_flag) && $stable(zero_flag)) [*2])
    else $error("skipped instruction was not suppressed once");

endmodule

// [sim/sequencer_model.sv]
`timescale 1ns/1ps
// sequencer side of the core: one register access at a time over the bus
module sequencer_model (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // bus idle from time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // address and data offered together; each dropped once taken, the answer ends the wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r, output bit ok);
    ok = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int n = 0; n < 1000 && !ok; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) begin
        bready <= 1'h0;
        r = bresp;
        ok = 1'h1;
      end
    end
  endtask

  // read: address held until taken, data taken at the edge rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r, output bit ok);
    ok = 1'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int n = 0; n < 1000 && !ok; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) begin
        rready <= 1'h0;
        d = rdata;
        r = rresp;
        ok = 1'h1;
      end
    end
  endtask
endmodule

// [sim/skip_judgement_unit_tb.sv]
`timescale 1ns/1ps
module skip_judgement_unit_tb;
  import sju_pkg::*;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, skip_request;
  bit          ok;
  int          mismatches = 0;
  int          cmp_count = 0;
  logic [3:0]  vals [4] = '{4'h0, 4'h7, 4'h8, 4'hF};

  // 250 MHz
  always #2 aclk = ~aclk;

  skip_judgement_unit skip_judgement_unit_i (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .skip_request(skip_request));

  sequencer_model sequencer_model_i (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  task automatic conclude();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  // a bus wait that runs out ends the run
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    sequencer_model_i.wr(a, v, resp, ok);
    if (!ok) begin
      mismatches++;
      conclude();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    sequencer_model_i.rd(a, v, resp, ok);
    if (!ok) begin
      mismatches++;
      conclude();
    end
  endtask

  // the status read waits behind the execution, since the bus is held off while busy
  task automatic exec(input judge_op_t op, input logic [3:0] n, input logic [3:0] a);
    wr(OFS_INSTR, {21'h0, op, n, a});
  endtask

  task automatic setm(input logic [3:0] a, input logic [3:0] v);
    wr(OFS_MEM_ADDR, {28'h0, a});
    wr(OFS_MEM_DATA, {28'h0, v});
  endtask

  // expected judgement, worked out from the operand values alone
  function automatic logic exp_skip(input judge_op_t op, input logic [3:0] m,
                                    input logic [3:0] n);
    case (op)
      skip_if_bits_set:         return (m & n) == n;
      skip_if_bits_clear:       return (m & n) == 4'h0;
      skip_if_equal:            return m == n;
      skip_if_not_equal:        return m != n;
      skip_if_greater_or_equal: return m >= n;
      default:                  return m < n;
    endcase
  endfunction

  initial begin
    judge_op_t op;
    logic      e;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    wr(OFS_INDEX, 32'h0);
    // every judgement against boundary operands, flags preset to catch stray writes
    for (int o = 0; o < 6; o++) begin
      for (int i = 0; i < 16; i++) begin
        op = judge_op_t'(o);
        e = exp_skip(op, vals[i / 4], vals[i % 4]);
        setm(4'h2, vals[i / 4]);
        wr(OFS_PSW, 32'h7);
        exec(op, vals[i % 4], 4'h2);
        rd(OFS_STATUS, d);
        chk(d & 32'h3, {30'h0, e, 1'h0}, "skip decision");
        chk({31'h0, skip_request}, {31'h0, e}, "skip request pin");
        rd(OFS_PSW, d);
        chk(d, (o < 2) ? 32'h3 : 32'h7, "status word after test");
        rd(OFS_MEM_DATA, d);
        chk(d, {28'h0, vals[i / 4]}, "operand kept");
        exec(no_operation, 4'h0, 4'h0);
      end
    end
    // indexed operand address wraps modulo 16
    wr(OFS_INDEX, 32'h3);
    setm(4'hE, 4'h0);
    setm(4'h1, 4'hF);
    wr(OFS_PSW, 32'h8);
    exec(skip_if_equal, 4'hF, 4'hE);
    rd(OFS_STATUS, d);
    chk(d & 32'h3, 32'h2, "indexed test");
    exec(no_operation, 4'h0, 4'h0);
    // compare-only arithmetic: flags change, memory does not
    setm(4'h5, 4'h9);
    wr(OFS_PSW, 32'h4);
    exec(add_immediate, 4'h8, 4'h5);
    rd(OFS_PSW, d);
    chk(d, 32'h5, "flags in compare-only add");
    rd(OFS_MEM_DATA, d);
    chk(d, 32'h9, "no write in compare-only add");
    wr(OFS_PSW, 32'h0);
    exec(add_immediate, 4'h8, 4'h5);
    rd(OFS_MEM_DATA, d);
    chk(d, 32'h1, "normal add writes");
    // exactly one instruction after a skip is suppressed without effect
    exec(skip_if_equal, 4'h1, 4'h5);
    wr(OFS_PSW, 32'h0);
    exec(add_immediate, 4'h3, 4'h5);
    rd(OFS_STATUS, d);
    chk(d, 32'h4, "suppressed issue");
    rd(OFS_MEM_DATA, d);
    chk(d, 32'h1, "suppressed add left memory");
    rd(OFS_PSW, d);
    chk(d, 32'h0, "suppressed add left flags");
    exec(add_immediate, 4'h3, 4'h5);
    rd(OFS_MEM_DATA, d);
    chk(d, 32'h4, "execution resumes");
    // compare-only chain: a zero result keeps zero, never sets it
    wr(OFS_PSW, 32'h6);
    exec(add_immediate, 4'hC, 4'h5);
    rd(OFS_PSW, d);
    chk(d, 32'h7, "zero kept in compare-only add");
    wr(OFS_PSW, 32'h4);
    exec(add_immediate, 4'hC, 4'h5);
    rd(OFS_PSW, d);
    chk(d, 32'h5, "zero not set in compare-only add");
    rd(OFS_MEM_DATA, d);
    chk(d, 32'h4, "compare-only chain left memory");
    // unmapped read and a write to the read-only status place
    rd(8'h18, d);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped read response");
    chk(d, 32'h0, "unmapped read data");
    wr(OFS_STATUS, 32'h7);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "status write refused");
    conclude();
  end
endmodule
